/* core/rmsw_top.sv */
// Reference frequency monitors and reference / holdover selection.
// Assumes references and pins are synchronous to clk; AXI4-Lite slave.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rmsw_top #(
   parameter int DIV_W = 16,
   parameter int CNT_W = 32
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [1:0]  ref_in,          // Bit 0 first, bit 1 second
   input  wire logic [1:0]  reference_lost,
   input  wire logic        ref_choice_pin_i,
   output logic             ref_choice_pin_o,
   output logic             ref_choice_pin_oe,
   input  wire logic        hold_pin_i,
   output logic             hold_pin_o,
   output logic             hold_pin_oe,
   output logic             active_ref,
   output logic             holdover,
   output logic [3:0]       status_pins,     // status_pin_one .. four
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // Software state
   logic [1:0]             mon_en_q;
   logic [DIV_W-1:0]       div_q [2];
   logic [CNT_W-1:0]       low_q [2];
   logic [CNT_W-1:0]       upp_q [2];
   logic [CNT_W-1:0]       capt_q [2];
   logic [1:0]             freq_out_of_limits_q;
   logic [1:0]             irq_stat_q;
   logic [7:0]             pin_map_q;     // 2 bits per status pin
   logic [1:0]             mon_armed;     // Monitor has seen a divided edge
   rmsw_pkg::rmsw_sel_cfg_s cfg_q;
   logic [1:0]             ref_dly_q;
   logic [1:0]             ref_rise;
   logic [1:0]             div_tick;
   logic [1:0]             ool_event;

   assign ref_rise = ref_in & ~ref_dly_q;

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         ref_dly_q <= 2'b00;
      else
         ref_dly_q <= ref_in;

   // One monitor per reference input
   for (genvar g = 0; g < 2; g++)
   begin : g_mon
      logic [DIV_W-1:0] dcnt_q;
      logic [CNT_W+1:0] pcnt_q;     // Counts clk; two extra low bits
      logic [CNT_W-1:0] quarter;
      logic             armed_q;
      logic             outside;
      // Dropping the two low bits makes the count run at clk / 4
      assign quarter      = pcnt_q[CNT_W+1:2];
      assign mon_armed[g] = armed_q;
      // A divided edge every div_q reference rising edges
      assign div_tick[g] = ref_rise[g] && (dcnt_q + DIV_W'(1) >= div_q[g]);
      // Count compares against the programmed window
      assign outside = (quarter < low_q[g]) || (quarter > upp_q[g]);
      // First interval after enable is partial, so it is not judged
      assign ool_event[g] = mon_en_q[g] && div_tick[g] && armed_q && outside;

      always_ff @(posedge clk or negedge arst_n)
         if (!arst_n)
         begin
            dcnt_q  <= '0;
            pcnt_q  <= '0;
            armed_q <= 1'b0;
            capt_q[g] <= '0;
         end
         else if (!mon_en_q[g])
         begin
            dcnt_q  <= '0;
            pcnt_q  <= '0;
            armed_q <= 1'b0;
         end
         else
         begin
            if (ref_rise[g])
               dcnt_q <= div_tick[g] ? '0 : dcnt_q + DIV_W'(1);
            // Counts system clocks, restart per divided edge
            if (div_tick[g])
            begin
               capt_q[g] <= quarter;
               pcnt_q    <= (CNT_W+2)'(1);
               armed_q   <= 1'b1;
            end
            else if (pcnt_q != '1)
               pcnt_q <= pcnt_q + (CNT_W+2)'(1);
         end
   end

   // Selection logic: machine, overrides and line card latch
   rmsw_pkg::rmsw_state_e st_q;
   logic [1:0] failed;
   logic       sm_ref, sm_hold, want_ref, want_hold, act_q, hold_q;
   assign failed  = reference_lost | freq_out_of_limits_q;
   assign sm_ref  = (st_q == rmsw_pkg::ST_SECOND) ||
                    (st_q == rmsw_pkg::ST_HOLD_SECOND);
   assign sm_hold = (st_q == rmsw_pkg::ST_HOLD_FIRST) ||
                    (st_q == rmsw_pkg::ST_HOLD_SECOND);
   // Manual pin low = first, high = second
   assign want_ref  = !cfg_q.auto_sel ? ref_choice_pin_i :
                      cfg_q.ref_ovrd ? cfg_q.manual_ref_choice_bit :
                      sm_ref;
   assign want_hold = !cfg_q.auto_hold ? hold_pin_i :
                      cfg_q.hold_ovrd ? cfg_q.hold_force : sm_hold;

   // Automatic machine: leave a failed reference, hold when both fail
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         st_q <= rmsw_pkg::ST_FIRST;
      else
         unique case (st_q)
            rmsw_pkg::ST_FIRST:
               if (failed[0])
                  st_q <= failed[1] ? rmsw_pkg::ST_HOLD_FIRST
                                    : rmsw_pkg::ST_SECOND;
            rmsw_pkg::ST_SECOND:
               if (failed[1])
                  st_q <= failed[0] ? rmsw_pkg::ST_HOLD_SECOND
                                    : rmsw_pkg::ST_FIRST;
            rmsw_pkg::ST_HOLD_FIRST, rmsw_pkg::ST_HOLD_SECOND:
               if (!failed[0])
                  st_q <= rmsw_pkg::ST_FIRST;
               else if (!failed[1])
                  st_q <= rmsw_pkg::ST_SECOND;
         endcase

   // Switch at once, or on the alternate reference's rising edge;
   // the edge wait avoids a runt pulse on the selected clock
   logic switch_ok;
   assign switch_ok = !cfg_q.line_card || ref_rise[want_ref];
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         act_q  <= 1'b0;
         hold_q <= 1'b0;
      end
      else
      begin
         if (want_ref != act_q && switch_ok)
            act_q <= want_ref;
         hold_q <= want_hold;
      end
   assign active_ref = act_q;
   assign holdover   = hold_q;

   // Pins show the machine's choice even under override
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         ref_choice_pin_o  <= 1'b0;
         ref_choice_pin_oe <= 1'b0;
         hold_pin_o        <= 1'b0;
         hold_pin_oe       <= 1'b0;
      end
      else
      begin
         ref_choice_pin_o  <= sm_ref;
         ref_choice_pin_oe <= cfg_q.auto_sel;
         hold_pin_o        <= sm_hold;
         hold_pin_oe       <= cfg_q.auto_hold;
      end

   // Status pin routing; map code 0 off, 1 flag 0, 2 flag 1
   for (genvar p = 0; p < 4; p++)
   begin : g_pin
      always_ff @(posedge clk or negedge arst_n)
         if (!arst_n)
            status_pins[p] <= 1'b0;
         else
            status_pins[p] <= (pin_map_q[2*p+:2] == 2'd1) ?
                                 freq_out_of_limits_q[0] :
                              (pin_map_q[2*p+:2] == 2'd2) ?
                                 freq_out_of_limits_q[1] : 1'b0;
   end

   // AXI4-Lite write path: address and data taken in either order
   logic        aw_q, w_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic        do_wr;
   logic        wr_hit;
   logic [1:0]  irq_clr;
   assign do_wr = aw_q && w_q && !s_axi_bvalid;
   assign irq_clr = (do_wr && awaddr_q == rmsw_pkg::OFF_IRQ_STAT) ?
                    wdata_q[1:0] : 2'b00;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= '0; wdata_q <= '0;
         s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= rmsw_pkg::RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1; wdata_q <= s_axi_wdata; s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? rmsw_pkg::RESP_OK : rmsw_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0;
            s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
         end
      end

   assign wr_hit = awaddr_q inside {rmsw_pkg::OFF_MON_CTRL, rmsw_pkg::OFF_DIV0,
      rmsw_pkg::OFF_DIV1, rmsw_pkg::OFF_LOW0, rmsw_pkg::OFF_LOW1,
      rmsw_pkg::OFF_UPP0, rmsw_pkg::OFF_UPP1, rmsw_pkg::OFF_IRQ_STAT,
      rmsw_pkg::OFF_PIN_MAP, rmsw_pkg::OFF_SEL_CFG0, rmsw_pkg::OFF_SEL_CFG1};

   // Register writes and flags; a new event wins over a clear
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         mon_en_q <= 2'b00; pin_map_q <= '0; cfg_q <= '0;
         div_q[0] <= rmsw_pkg::DIV_RST; div_q[1] <= rmsw_pkg::DIV_RST;
         low_q[0] <= rmsw_pkg::LIM_RST; low_q[1] <= rmsw_pkg::LIM_RST;
         upp_q[0] <= rmsw_pkg::UPP_RST; upp_q[1] <= rmsw_pkg::UPP_RST;
         freq_out_of_limits_q <= 2'b00; irq_stat_q <= 2'b00;
      end
      else
      begin
         // Live flag follows each judged interval; disabled reads clear
         for (int i = 0; i < 2; i++)
            if (!mon_en_q[i])
               freq_out_of_limits_q[i] <= 1'b0;
            else if (div_tick[i] && mon_armed[i])
               freq_out_of_limits_q[i] <= ool_event[i];
         irq_stat_q <= (irq_stat_q & ~irq_clr) | ool_event;
         if (do_wr)
            unique case (awaddr_q)
               rmsw_pkg::OFF_MON_CTRL: mon_en_q <= wdata_q[1:0];
               rmsw_pkg::OFF_DIV0: div_q[0] <= wdata_q[DIV_W-1:0];
               rmsw_pkg::OFF_DIV1: div_q[1] <= wdata_q[DIV_W-1:0];
               rmsw_pkg::OFF_LOW0: low_q[0] <= wdata_q;
               rmsw_pkg::OFF_LOW1: low_q[1] <= wdata_q;
               rmsw_pkg::OFF_UPP0: upp_q[0] <= wdata_q;
               rmsw_pkg::OFF_UPP1: upp_q[1] <= wdata_q;
               rmsw_pkg::OFF_PIN_MAP: pin_map_q <= wdata_q[7:0];
               rmsw_pkg::OFF_SEL_CFG0:
               begin
                  cfg_q.auto_hold <= wdata_q[rmsw_pkg::BIT_AUTO_HOLD];
                  cfg_q.auto_sel  <= wdata_q[rmsw_pkg::BIT_AUTO_SEL];
               end
               rmsw_pkg::OFF_SEL_CFG1:
               begin
                  cfg_q.hold_force <= wdata_q[rmsw_pkg::BIT_HOLD_FORCE];
                  cfg_q.hold_ovrd  <= wdata_q[rmsw_pkg::BIT_HOLD_OVRD];
                  cfg_q.manual_ref_choice_bit <=
                     wdata_q[rmsw_pkg::BIT_MANUAL_REF];
                  cfg_q.ref_ovrd   <= wdata_q[rmsw_pkg::BIT_REF_OVRD];
                  cfg_q.line_card  <= wdata_q[rmsw_pkg::BIT_LINE_CARD];
               end
               default: ;
            endcase
      end

   // AXI4-Lite read path: one cycle from address to data
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      unique case (s_axi_araddr)
         rmsw_pkg::OFF_MON_CTRL: rd_mux = {30'h0, mon_en_q};
         rmsw_pkg::OFF_DIV0:     rd_mux = 32'(div_q[0]);
         rmsw_pkg::OFF_DIV1:     rd_mux = 32'(div_q[1]);
         rmsw_pkg::OFF_LOW0:     rd_mux = low_q[0];
         rmsw_pkg::OFF_LOW1:     rd_mux = low_q[1];
         rmsw_pkg::OFF_UPP0:     rd_mux = upp_q[0];
         rmsw_pkg::OFF_UPP1:     rd_mux = upp_q[1];
         rmsw_pkg::OFF_CAPT0:    rd_mux = capt_q[0];
         rmsw_pkg::OFF_CAPT1:    rd_mux = capt_q[1];
         rmsw_pkg::OFF_STATUS:
            rd_mux = {24'h0, 2'b00, act_q, hold_q, reference_lost,
                      freq_out_of_limits_q};
         rmsw_pkg::OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
         rmsw_pkg::OFF_PIN_MAP:  rd_mux = {24'h0, pin_map_q};
         rmsw_pkg::OFF_SEL_CFG0:
            rd_mux = {29'h0, cfg_q.auto_sel, 1'b0, cfg_q.auto_hold};
         rmsw_pkg::OFF_SEL_CFG1:
            rd_mux = {27'h0, cfg_q.line_card, cfg_q.ref_ovrd,
                      cfg_q.manual_ref_choice_bit, cfg_q.hold_ovrd,
                      cfg_q.hold_force};
         default: rd_mux = '0;
      endcase
   end
   logic rd_known;
   assign rd_known = wr_hit_rd(s_axi_araddr);
   function automatic logic wr_hit_rd(input logic [11:0] a);
      wr_hit_rd = a inside {rmsw_pkg::OFF_MON_CTRL, rmsw_pkg::OFF_DIV0,
         rmsw_pkg::OFF_DIV1, rmsw_pkg::OFF_LOW0, rmsw_pkg::OFF_LOW1,
         rmsw_pkg::OFF_UPP0, rmsw_pkg::OFF_UPP1, rmsw_pkg::OFF_IRQ_STAT,
         rmsw_pkg::OFF_PIN_MAP, rmsw_pkg::OFF_SEL_CFG0, rmsw_pkg::OFF_SEL_CFG1,
         rmsw_pkg::OFF_STATUS, rmsw_pkg::OFF_CAPT0, rmsw_pkg::OFF_CAPT1};
   endfunction

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0; s_axi_rresp <= rmsw_pkg::RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? rmsw_pkg::RESP_OK : rmsw_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0; s_axi_arready <= 1'b1;
      end

   // Checks
   irq_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
      ool_event[0] |=> irq_stat_q[0]) else $error("irq bit 0 not set");
   manual_ref_a: assert property (@(posedge clk) disable iff (!arst_n)
      !cfg_q.auto_sel && !cfg_q.line_card |=>
      act_q == $past(ref_choice_pin_i))
      else $error("manual ref not followed");
   pin_shows_sm_a: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_q.auto_sel |=> ref_choice_pin_oe && ref_choice_pin_o == $past(sm_ref))
      else $error("select pin not machine choice");
   line_card_a: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_q.line_card && !ref_rise[want_ref] |=> act_q == $past(act_q))
      else $error("switch off edge");
   hold_manual_a: assert property (@(posedge clk) disable iff (!arst_n)
      !cfg_q.auto_hold |=> hold_q == $past(hold_pin_i))
      else $error("manual holdover");
   mon_off_a: assert property (@(posedge clk) disable iff (!arst_n)
      !mon_en_q[1] |=> !freq_out_of_limits_q[1])
      else $error("disabled monitor");
   fail_leave_a: assert property (@(posedge clk) disable iff (!arst_n)
      st_q == rmsw_pkg::ST_FIRST && failed == 2'b01 |=>
      st_q == rmsw_pkg::ST_SECOND) else $error("no failover");
   ovrd_ref_a: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_q.auto_sel && cfg_q.ref_ovrd && !cfg_q.line_card |=>
      act_q == $past(cfg_q.manual_ref_choice_bit))
      else $error("override");
   c_ool: cover property (@(posedge clk) ool_event[0]);
   c_switch: cover property (@(posedge clk) $changed(act_q));
   c_hold: cover property (@(posedge clk) sm_hold);
endmodule // rmsw_top
`default_nettype wire

/* shared/rmsw_pkg.sv */
// Shared constants and types for the reference monitor / switchover block.
// Assumes a single system clock domain and an AXI4-Lite register port.
`default_nettype none
package rmsw_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_MON_CTRL  = 12'h000;
   localparam logic [11:0] OFF_DIV0      = 12'h004;
   localparam logic [11:0] OFF_DIV1      = 12'h008;
   localparam logic [11:0] OFF_LOW0      = 12'h00C;
   localparam logic [11:0] OFF_LOW1      = 12'h010;
   localparam logic [11:0] OFF_UPP0      = 12'h014;
   localparam logic [11:0] OFF_UPP1      = 12'h018;
   localparam logic [11:0] OFF_STATUS    = 12'h01C;
   localparam logic [11:0] OFF_IRQ_STAT  = 12'h020;
   localparam logic [11:0] OFF_PIN_MAP   = 12'h024;
   localparam logic [11:0] OFF_SEL_CFG0  = 12'h1C0;
   localparam logic [11:0] OFF_SEL_CFG1  = 12'h1C4;
   localparam logic [11:0] OFF_CAPT0     = 12'h028;
   localparam logic [11:0] OFF_CAPT1     = 12'h02C;
   // Field positions
   localparam int BIT_AUTO_HOLD   = 0;
   localparam int BIT_AUTO_SEL    = 2;
   localparam int BIT_HOLD_FORCE  = 0;
   localparam int BIT_HOLD_OVRD   = 1;
   localparam int BIT_MANUAL_REF  = 2;
   localparam int BIT_REF_OVRD    = 3;
   localparam int BIT_LINE_CARD   = 4;
   // Reset values and AXI response codes
   localparam logic [15:0] DIV_RST   = 16'h0001;
   localparam logic [31:0] LIM_RST   = 32'h0000_0000;
   localparam logic [31:0] UPP_RST   = 32'hFFFF_FFFF;
   localparam logic [1:0]  RESP_OK     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic       auto_sel;
      logic       auto_hold;
      logic       ref_ovrd;
      logic       manual_ref_choice_bit;
      logic       hold_ovrd;
      logic       hold_force;
      logic       line_card;
   } rmsw_sel_cfg_s;

   typedef enum logic [1:0] {
      ST_FIRST, ST_SECOND, ST_HOLD_FIRST, ST_HOLD_SECOND
   } rmsw_state_e;
endpackage : rmsw_pkg
`default_nettype wire

/* bench/rmsw_ref_model.sv */
// Model of the two reference sources that feed the frequency monitors.
// Assumes clk is the system clock; half periods are counted in clk cycles.
`timescale 1ns/1ns
`default_nettype none
module rmsw_ref_model (
   input  wire logic            clk,
   input  wire logic            arst_n,
   input  wire logic [1:0][7:0] half,
   output logic      [1:0]      ref_out
);
   logic [1:0][7:0] cnt_q;

   // Each source toggles every half clk cycles; a zero half period parks it
   // low, so a stalled source shows no rising edge once parked
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         cnt_q   <= 16'h0000;
         ref_out <= 2'h0;
      end
      else
         for (int i = 0; i < 2; i++)
            if (half[i] == 8'h00 || cnt_q[i] == half[i] - 8'h01)
            begin
               cnt_q[i]   <= 8'h00;
               ref_out[i] <= (half[i] != 8'h00) && !ref_out[i];
            end
            else
               cnt_q[i] <= cnt_q[i] + 8'h01;
endmodule // rmsw_ref_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for rmsw_top: AXI4-Lite master tasks, a row table of
// register accesses, then hand-written monitor and selection cases.
// Assumes the reference model drives ref_in synchronously to clk.
`timescale 1ns/1ns
`default_nettype none
module tb;
   // Ref0 period 100 clk, divider 3: nominal 75, limits 55 and 95
   localparam logic [7:0]  HALF0 = 8'h32;
   localparam logic [7:0]  HALF1 = 8'h1E;
   localparam logic [31:0] DIVV  = 32'h0000_0003; // Odd divider
   localparam logic [31:0] WIN   = 32'h0000_0014; // Window 20
   // No loop filter lives here, so bandwidth limits stay with software
   localparam logic [31:0] NOM   = 32'(HALF0) * 2 * DIVV / 4;
   localparam logic [31:0] LOWL  = NOM - WIN; // Exact integer
   localparam logic [31:0] UPPL  = NOM + WIN; // Exact integer
   localparam int          SPAN  = 4 * int'(NOM); // Interval in clk
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic        err;
   } rmsw_row_s;
   logic            clk, arst_n, sel_drv, hold_drv;
   logic [1:0]      lost;
   logic [1:0][7:0] half;
   wire logic [1:0] ref_in;
   logic            sel_o, sel_oe, hold_o, hold_oe, act, hold;
   logic [3:0]      pins, s_axi_wstrb;
   logic [11:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]     s_axi_wdata, s_axi_rdata, rdat;
   logic [1:0]      s_axi_bresp, s_axi_rresp, rsp;
   logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic            s_axi_rvalid, s_axi_rready;
   int              bad_count, checks;

   // Two-way pins: the design wins while its enable is high
   wire logic sel_i  = sel_oe ? sel_o : sel_drv;
   wire logic hold_i = hold_oe ? hold_o : hold_drv;

   rmsw_top i_rmsw_top (.clk, .arst_n, .ref_in, .reference_lost(lost),
      .ref_choice_pin_i(sel_i), .ref_choice_pin_o(sel_o),
      .ref_choice_pin_oe(sel_oe), .hold_pin_i(hold_i), .hold_pin_o(hold_o),
      .hold_pin_oe(hold_oe), .active_ref(act), .holdover(hold),
      .status_pins(pins), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   rmsw_ref_model i_rmsw_ref_model (.clk, .arst_n, .half, .ref_out(ref_in));

   // 125 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Waits a bounded time for a level, then compares it
   task automatic wchk(ref logic s, input logic e);
      for (int n = 0; n < 160 && s !== e; n++) @(posedge clk);
      chk(32'(s), 32'(e));
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rdat = s_axi_rdata;
      rsp  = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic results;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Reset reads, an unmapped place, then the monitor setup with readback
   rmsw_row_s rows [14] = '{
      '{1'b0, rmsw_pkg::OFF_DIV0, 32'h0, 32'(rmsw_pkg::DIV_RST), 1'b0},
      '{1'b0, rmsw_pkg::OFF_LOW0, 32'h0, rmsw_pkg::LIM_RST, 1'b0},
      '{1'b0, rmsw_pkg::OFF_UPP1, 32'h0, rmsw_pkg::UPP_RST, 1'b0},
      '{1'b0, rmsw_pkg::OFF_SEL_CFG1, 32'h0, 32'h0, 1'b0},
      '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1},
      '{1'b1, 12'h100, 32'hFFFF_FFFF, 32'h0, 1'b1},
      '{1'b1, rmsw_pkg::OFF_DIV0, DIVV, DIVV, 1'b0},
      '{1'b1, rmsw_pkg::OFF_DIV1, DIVV, DIVV, 1'b0},
      '{1'b1, rmsw_pkg::OFF_LOW0, LOWL, LOWL, 1'b0},
      '{1'b1, rmsw_pkg::OFF_LOW1, LOWL, LOWL, 1'b0},
      '{1'b1, rmsw_pkg::OFF_UPP0, UPPL, UPPL, 1'b0},
      '{1'b1, rmsw_pkg::OFF_UPP1, UPPL, UPPL, 1'b0},
      '{1'b1, rmsw_pkg::OFF_PIN_MAP, 32'h86, 32'h86, 1'b0},
      '{1'b1, rmsw_pkg::OFF_MON_CTRL, 32'h3, 32'h3, 1'b0}};

   // Main sequence; ref1 runs at 45 nominal counts, below the lower limit
   initial
   begin
      {arst_n, sel_drv, hold_drv, lost, s_axi_awvalid, s_axi_wvalid} = 7'h00;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hF;
      half = {HALF1, HALF0};
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         if (rows[i].w) chk(32'(rsp), 32'(rows[i].err ? 2'h2 : 2'h0));
         rd(rows[i].a);
         chk(rdat, rows[i].e); // readback
         chk(32'(rsp), 32'(rows[i].err ? 2'h2 : 2'h0)); // response
      end
      repeat (4 * SPAN) @(posedge clk);
      rd(rmsw_pkg::OFF_STATUS);
      chk(32'(rdat[1:0]), 32'h2); // ref1 low
      rd(rmsw_pkg::OFF_IRQ_STAT);
      chk(32'(rdat[1:0]), 32'h2); // sticky copy
      chk(32'(pins), 32'h9); // routed flags
      wr(rmsw_pkg::OFF_MON_CTRL, 32'h1);
      wr(rmsw_pkg::OFF_IRQ_STAT, 32'h3);
      half[0] <= 8'h48; // Ref0 slower: count 108, above upper limit
      repeat (4 * SPAN) @(posedge clk);
      rd(rmsw_pkg::OFF_STATUS);
      chk(32'(rdat[1:0]), 32'h1); // ref1 off, ref0 high
      chk(32'(pins), 32'h2); // routed flags
      half[0] <= HALF0;
      wr(rmsw_pkg::OFF_MON_CTRL, 32'h0);
      sel_drv <= 1'b1;
      wchk(act, 1'b1); // manual high
      chk(32'(sel_oe), 32'h0); // pin is input
      sel_drv <= 1'b0;
      wchk(act, 1'b0); // manual low
      hold_drv <= 1'b1;
      wchk(hold, 1'b1); // manual hold
      hold_drv <= 1'b0;
      wchk(hold, 1'b0); // manual track
      // Line card: a parked ref1 must hold the switch off
      half[1]  <= 8'h00; // Parked well before the request, no stray edge
      wr(rmsw_pkg::OFF_SEL_CFG1, 32'h10);
      sel_drv  <= 1'b1;
      repeat (100) @(posedge clk);
      chk(32'(act), 32'h0); // no edge yet
      half[1] <= HALF1;
      wchk(act, 1'b1); // after edge
      wr(rmsw_pkg::OFF_SEL_CFG1, 32'h0);
      sel_drv <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(act), 32'h0); // at once, no edge wait
      // Automatic selection, override and holdover
      wr(rmsw_pkg::OFF_SEL_CFG0, 32'h4);
      wchk(sel_oe, 1'b1); // pin driven
      // The earlier ref0 fault already moved the machine to ref1
      wchk(sel_o, 1'b1); // machine stays on ref1
      wchk(act, 1'b1); // active follows machine
      lost <= 2'h2;
      wchk(act, 1'b0); // ref1 failed
      wchk(sel_o, 1'b0); // pin shows choice
      lost <= 2'h1;
      wchk(act, 1'b1); // ref0 failed
      wchk(sel_o, 1'b1); // pin shows choice
      wr(rmsw_pkg::OFF_SEL_CFG1, 32'h8);
      wchk(act, 1'b0); // forced ref0
      chk(32'(sel_o), 32'h1); // machine view kept
      wr(rmsw_pkg::OFF_SEL_CFG0, 32'h5);
      wchk(hold_oe, 1'b1); // hold pin driven
      lost <= 2'h3;
      wchk(hold_o, 1'b1); // both failed
      wr(rmsw_pkg::OFF_SEL_CFG1, 32'h2);
      wchk(hold, 1'b0); // forced tracking
      chk(32'(hold_o), 32'h1); // machine view kept
      results;
   end

   // Whole run needs about 3000 cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      results;
   end
endmodule // tb
`default_nettype wire
